// *** src/bies_event_select.sv ***
// event selector producing a registered per-cycle count qualifier
`include "bies_cfg.svh"
module bies_event_select
(
   input wire logic ref_clk_in, // core clock
   input wire logic sys_rst_in, // synchronous reset, active high
   input wire logic [7:0] event_num_in, // programmed event number
   input wire logic [7:0] unit_mask_in, // programmed unit mask
   input wire logic branch_retire_in, // a branch retires this cycle
   input wire logic branch_taken_in, // its actual direction was taken
   input wire logic branch_pred_taken_in, // its predicted direction was taken
   input wire logic int_disabled_in, // interrupt acceptance disabled
   input wire logic int_pending_in, // at least one interrupt pending
   output logic count_qual_out // one count this cycle, straight from a flip-flop
);

   // selection state: the decode is registered so that the sixteen-bit
   // compare never sits in front of the qualifier flip-flop
   bies_pkg::bies_sel_type sel; // registered selection
   bies_pkg::bies_sel_type next_sel; // selection the decode asks for

   // qualifier state
   logic next_count_qual; // qualifier value for the coming edge

   // event terms shared by several selections
   logic retired_taken; // a retired branch that went the taken way
   logic mispred; // a retired branch whose direction was predicted wrong
   logic pending_masked; // a pending interrupt while acceptance is off

   // exact decode of event number and unit mask together; a match on
   // either half alone must not select anything
   always_comb
   begin
      // refused unless one of the five encodings matches in full
      next_sel = bies_pkg::SEL_NONE;
      case ({event_num_in, unit_mask_in})
         // retired taken branches
         {`BIES_EVT_BRANCH, `BIES_UM_TAKEN}: next_sel = bies_pkg::SEL_TAKEN;
         // duplicate of the mispredict count under the branch event
         {`BIES_EVT_BRANCH, `BIES_UM_ALIAS}: next_sel = bies_pkg::SEL_ALIAS;
         // retired mispredicted branches
         {`BIES_EVT_MISPRED, `BIES_UM_MISPRED}: next_sel = bies_pkg::SEL_MISPRED;
         // cycles with interrupt acceptance off
         {`BIES_EVT_INTMASK, `BIES_UM_DISABLED}: next_sel = bies_pkg::SEL_DISABLED;
         // cycles with a pending interrupt held off
         {`BIES_EVT_INTMASK, `BIES_UM_PENDING}: next_sel = bies_pkg::SEL_PENDING;
         // every other pairing, near misses included, counts nothing
         default: next_sel = bies_pkg::SEL_NONE;
      endcase
   end

   // taken counts only at retirement; the prediction plays no part here
   assign retired_taken = branch_retire_in && branch_taken_in;

   // mispredict qualified by retirement only, so work on a discarded
   // path never reaches the count
   assign mispred = branch_retire_in && (branch_taken_in != branch_pred_taken_in);

   // a pending interrupt only counts while acceptance is switched off
   assign pending_masked = int_disabled_in && int_pending_in;

   // qualifier uses the selection registered last cycle; a reprogram
   // therefore lags one edge, the price of the registered decode
   always_comb
   begin
      // nothing counts unless a supported selection is held
      next_count_qual = 1'h0;
      case (sel)
         // one count per retired taken branch
         bies_pkg::SEL_TAKEN: next_count_qual = retired_taken;
         // same source as the dedicated mispredict selection, so counts agree
         bies_pkg::SEL_ALIAS: next_count_qual = mispred;
         // retired mispredicts only
         bies_pkg::SEL_MISPRED: next_count_qual = mispred;
         // level event: high on every masked cycle
         bies_pkg::SEL_DISABLED: next_count_qual = int_disabled_in;
         // level event: high on every cycle with a pending interrupt held off
         bies_pkg::SEL_PENDING: next_count_qual = pending_masked;
         // no selection, or a code the decode never makes
         default: next_count_qual = 1'h0;
      endcase
   end

   // selection register; reset leaves no selection, so the first edge
   // after release can never count
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         // cleared in reset
         sel <= bies_pkg::SEL_NONE;
      end
      else
      begin
         // take the decode of this cycle's encoding
         sel <= next_sel;
      end
   end

   // qualifier register; the output leaves straight from this flip-flop
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         // no count while the core is in reset
         count_qual_out <= 1'h0;
      end
      else
      begin
         // one edge from event to count
         count_qual_out <= next_count_qual;
      end
   end

   // checks: the named steps first, then the properties built from them

   // a retired branch whose outcome differed from its prediction
   sequence s_retire_mispred;
      branch_retire_in && (branch_taken_in != branch_pred_taken_in);
   endsequence

   // a retired branch that went the taken way
   sequence s_retire_taken;
      branch_retire_in && branch_taken_in;
   endsequence

   // a pending interrupt while acceptance is off
   sequence s_pending_masked;
      int_disabled_in && int_pending_in;
   endsequence

   // the five supported encodings as they stand on the inputs
   sequence s_code_taken;
      (event_num_in == `BIES_EVT_BRANCH) && (unit_mask_in == `BIES_UM_TAKEN);
   endsequence

   sequence s_code_alias;
      (event_num_in == `BIES_EVT_BRANCH) && (unit_mask_in == `BIES_UM_ALIAS);
   endsequence

   sequence s_code_mispred;
      (event_num_in == `BIES_EVT_MISPRED) && (unit_mask_in == `BIES_UM_MISPRED);
   endsequence

   sequence s_code_disabled;
      (event_num_in == `BIES_EVT_INTMASK) && (unit_mask_in == `BIES_UM_DISABLED);
   endsequence

   sequence s_code_pending;
      (event_num_in == `BIES_EVT_INTMASK) && (unit_mask_in == `BIES_UM_PENDING);
   endsequence

   // any pairing outside the five
   sequence s_code_refused;
      !(((event_num_in == `BIES_EVT_BRANCH) && (unit_mask_in == `BIES_UM_TAKEN)) ||
         ((event_num_in == `BIES_EVT_BRANCH) && (unit_mask_in == `BIES_UM_ALIAS)) ||
         ((event_num_in == `BIES_EVT_MISPRED) && (unit_mask_in == `BIES_UM_MISPRED)) ||
         ((event_num_in == `BIES_EVT_INTMASK) && (unit_mask_in == `BIES_UM_DISABLED)) ||
         ((event_num_in == `BIES_EVT_INTMASK) && (unit_mask_in == `BIES_UM_PENDING)));
   endsequence

   // held selection against last cycle's inputs
   AST_TAKEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_TAKEN) |=>
      (count_qual_out == ($past(branch_retire_in) && $past(branch_taken_in))))
      else $error("taken branch qualifier wrong");

   AST_ALIAS: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_ALIAS) ##0 s_retire_mispred |=> count_qual_out)
      else $error("alias mispredict not counted");

   AST_MISPRED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_MISPRED) ##0 s_retire_mispred |=> count_qual_out)
      else $error("mispredict not counted");

   // wrong-path work shows no retirement, so it must never count
   AST_PRECISE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ((sel == bies_pkg::SEL_MISPRED) || (sel == bies_pkg::SEL_ALIAS)) && !branch_retire_in
      |=> !count_qual_out)
      else $error("count without retirement");

   AST_DISABLED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_DISABLED) |=> (count_qual_out == $past(int_disabled_in)))
      else $error("disabled cycle qualifier wrong");

   AST_PENDING: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_PENDING) |=>
      (count_qual_out == ($past(int_disabled_in) && $past(int_pending_in))))
      else $error("pending cycle qualifier wrong");

   AST_NONE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sel == bies_pkg::SEL_NONE) |=> !count_qual_out)
      else $error("count with unsupported encoding");

   // an unknown event number gives no count two edges on
   AST_DECODE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ((event_num_in != `BIES_EVT_BRANCH) && (event_num_in != `BIES_EVT_MISPRED) &&
      (event_num_in != `BIES_EVT_INTMASK)) ##1 1'h1 |=> !count_qual_out)
      else $error("unknown event number counted");

   // reset leaves nothing counting at the edge after it
   AST_RESET_QUIET: assert property (@(posedge ref_clk_in)
      sys_rst_in |=> !count_qual_out)
      else $error("count right after reset");

   // end to end: encoding at one edge, event at the next, count one edge later
   AST_TAKEN_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_taken ##1 s_retire_taken |=> count_qual_out)
      else $error("taken branch path lost a count");

   AST_ALIAS_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_alias ##1 s_retire_mispred |=> count_qual_out)
      else $error("alias path lost a count");

   AST_MISPRED_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_mispred ##1 s_retire_mispred |=> count_qual_out)
      else $error("mispredict path lost a count");

   AST_PRECISE_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_mispred ##1 !branch_retire_in |=> !count_qual_out)
      else $error("mispredict path counted without retirement");

   AST_DISABLED_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_disabled ##1 int_disabled_in |=> count_qual_out)
      else $error("disabled cycle path lost a count");

   AST_PENDING_PATH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_pending ##1 s_pending_masked |=> count_qual_out)
      else $error("pending cycle path lost a count");

   // a pending interrupt with acceptance on is not a held-off cycle
   AST_PENDING_OPEN: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_pending ##1 !int_disabled_in |=> !count_qual_out)
      else $error("pending counted with acceptance on");

   // a refused pairing, whatever half matches, gives no count two edges on
   AST_REFUSED: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_code_refused ##1 1'h1 |=> !count_qual_out)
      else $error("refused encoding counted");
endmodule // bies_event_select

// *** src/bies_cfg.svh ***
// constants for the branch and interrupt-mask event selector
//
// What this block does
// - event C4H mask 0CH counts retired taken branches
// - event C4H mask 0FH counts retired mispredicts too
// - event C5H mask 00H counts retired mispredicted branches
// - mispredict count is precise: retired branches only
// - event C6H mask 01H counts interrupt-disabled cycles
// - event C6H mask 02H counts pending-while-disabled cycles
`ifndef BIES_CFG_SVH
`define BIES_CFG_SVH
`define BIES_EVT_BRANCH 8'hc4
`define BIES_EVT_MISPRED 8'hc5
`define BIES_EVT_INTMASK 8'hc6
`define BIES_UM_TAKEN 8'h0c
`define BIES_UM_ALIAS 8'h0f
`define BIES_UM_MISPRED 8'h00
`define BIES_UM_DISABLED 8'h01
`define BIES_UM_PENDING 8'h02
`endif

// *** src/bies_pkg.sv ***
// types for the branch and interrupt-mask event selector
package bies_pkg;
   // decoded selection
   typedef enum logic [2:0]
   {
      SEL_NONE = 3'b000, // no supported encoding: nothing counts
      SEL_TAKEN = 3'b001, // retired_taken_branch_event
      SEL_ALIAS = 3'b010, // retired_branch_alias_event
      SEL_MISPRED = 3'b011, // retired_mispredicted_branch_event
      SEL_DISABLED = 3'b100, // interrupt_disabled_cycle_event
      SEL_PENDING = 3'b101 // pending_while_disabled_cycle_event
   } bies_sel_type;
endpackage

// *** bench/branch_intmask_event_select_tb.sv ***
// self-checking bench for the branch and interrupt-mask event selector
module branch_intmask_event_select_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'h0, rst = 1'h1; // core clock, reset held 12 cycles
   logic [7:0] ev = 8'hc6, um = 8'h01; // encoding, valid already in reset
   // event inputs, msb first: retire, taken, predicted taken, disabled, pending
   logic [4:0] v = 5'h02;
   logic q; // count qualifier from the selector
   int failures = 0, num_checks = 0, cyc = 0;
   always #2.5 clk = ~clk;
   bies_event_select u_dut (.ref_clk_in(clk), .sys_rst_in(rst), .event_num_in(ev),
      .unit_mask_in(um), .branch_retire_in(v[4]), .branch_taken_in(v[3]),
      .branch_pred_taken_in(v[2]), .int_disabled_in(v[1]), .int_pending_in(v[0]),
      .count_qual_out(q));
   // verdict; a hang counts as one more mismatch
   task automatic summarize(input bit hang);
      failures += hang;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard, well above the 64 cycles the run needs
   always @(posedge clk)
      if (++cyc == 400)
         summarize(1'h1);
   // one comparison of the qualifier, judged at a falling edge where it is settled
   task automatic chk(input logic x);
      num_checks++;
      if (q !== x)
      begin
         failures++;
         $display("BAD count_qual_out exp %b got %b ev %h um %h in %h", x, q, ev, um, v);
      end
   endtask
   // selection settles on the first edge, events land on the second
   task automatic st(input logic [7:0] e, input logic [7:0] m, input logic [4:0] s,
      input logic x);
      ev = e;
      um = m;
      v = s;
      repeat (2) @(negedge clk);
      chk(x);
   endtask
   // release with the disabled-cycle code already set: quiet at the first edge,
   // counting at the second once the selection has been taken
   task automatic t_reset;
      repeat (12) @(negedge clk);
      chk(1'h0); // output held low in reset
      rst = 1'h0;
      @(negedge clk);
      chk(1'h0);
      @(negedge clk);
      chk(1'h1);
      $display("reset release done");
   endtask
   // supported selections, each with a case that must count and one that must not
   task automatic t_events;
      st(8'hc4, 8'h0c, 5'h1c, 1'h1);
      st(8'hc4, 8'h0c, 5'h18, 1'h1);
      st(8'hc4, 8'h0c, 5'h10, 1'h0);
      st(8'hc4, 8'h0f, 5'h14, 1'h1);
      st(8'hc4, 8'h0f, 5'h1c, 1'h0);
      st(8'hc4, 8'h0f, 5'h04, 1'h0);
      st(8'hc5, 8'h00, 5'h18, 1'h1);
      st(8'hc5, 8'h00, 5'h14, 1'h1);
      st(8'hc5, 8'h00, 5'h1c, 1'h0);
      st(8'hc5, 8'h00, 5'h08, 1'h0);
      st(8'hc6, 8'h01, 5'h02, 1'h1);
      st(8'hc6, 8'h01, 5'h01, 1'h0);
      st(8'hc6, 8'h02, 5'h02, 1'h0);
      st(8'hc6, 8'h02, 5'h01, 1'h0);
      st(8'hc6, 8'h02, 5'h03, 1'h1);
      $display("supported selections done");
   endtask
   // near-miss encodings with every event input high must stay silent
   task automatic t_refused;
      st(8'hc4, 8'h0d, 5'h1f, 1'h0);
      st(8'hc7, 8'h01, 5'h1f, 1'h0);
      st(8'hc5, 8'h0c, 5'h1f, 1'h0);
      st(8'hc6, 8'h00, 5'h1f, 1'h0);
      st(8'hc6, 8'h03, 5'h1f, 1'h0);
      $display("refused encodings done");
   endtask
   // a reprogram takes one edge to land: the old selection judges that edge
   task automatic t_switch;
      st(8'hc6, 8'h01, 5'h02, 1'h1);
      ev = 8'hc4;
      um = 8'h0c;
      @(negedge clk);
      chk(1'h1);
      @(negedge clk);
      chk(1'h0);
      $display("reprogram lag done");
   endtask
   // reset in mid-run clears a live selection; counting resumes two edges on
   task automatic t_mid_reset;
      st(8'hc6, 8'h01, 5'h02, 1'h1);
      rst = 1'h1;
      @(negedge clk);
      chk(1'h0); // cleared in reset
      @(negedge clk);
      chk(1'h0); // still in reset
      rst = 1'h0;
      @(negedge clk);
      chk(1'h0);
      @(negedge clk);
      chk(1'h1);
      $display("mid-run reset done");
   endtask
   initial
   begin
      t_reset();
      t_events();
      t_refused();
      t_switch();
      t_mid_reset();
      summarize(1'h0);
   end
endmodule // branch_intmask_event_select_tb
